//--- hdl/ldc_regs.sv
// LED drive configuration register bank with Time Slot A pulse shaping.
`timescale 1ns/100ps

module ldc_regs
    import ldc_pkg::*;
(
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst,
    // Register port from the serial host interface
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic                reg_wr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_rd,
    output      logic [DATA_W-1:0]   reg_rdata,
    output      logic                reg_rvalid,
    // Driver settings and peak targets
    output      ldc_drv_cfg_t        drv_cfg [DRV_COUNT],
    output      logic [TARGET_W-1:0] drv_peak_target [DRV_COUNT],
    // Time Slot A pulse shape
    output      ldc_slot_t           first_slot
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    ldc_drv_cfg_t drv [DRV_COUNT];
    logic [4:0]   first_slot_pulse_len;
    logic [7:0]   first_slot_pulse_delay;
    ldc_pick_t    first_slot_driver_pick;
    logic [DATA_W-1:0] next_rdata;

    // Register map, all words 16 bits wide:
    //   slot A driver pick  - pick in the two low bits, reset to the first driver.
    //   third, first and second driver control words, in rising offset order -
    //     scale at bit 13, fixed one at bit 12, edge rate and coarse level below.
    //   shared trim word    - third, second and first driver trims, high to low.
    //   slot A pulse shape  - pulse length above, pulse delay in the low byte.
    // Every field but the fixed one at bit 12 is read-write; a write replaces all fields of its word at once,
    // so software that changes one field must read, merge and write back.

    // Builds the read image of one driver control word; reserved bits show fixed values.
    function automatic logic [DATA_W-1:0] drv_word(input ldc_drv_cfg_t d);
        logic [DATA_W-1:0] w;
        w = '0;
        w[POS_SCALE]                 = d.full_strength;
        w[POS_RSVD_ONE]              = RSVD_ONE;
        w[POS_RATE_HI:POS_RATE_LO]   = d.edge_rate;
        w[POS_COARSE_HI:POS_COARSE_LO] = d.coarse_level;
        return w;
    endfunction

    // Maps a register offset to a driver index; the index order is led1, led2, led3.
    function automatic int drv_index(input logic [ADDR_W-1:0] a);
        case (a)
            OFF_LED1_DRIVE_CTL: drv_index = 0;
            OFF_LED2_DRIVE_CTL: drv_index = 1;
            OFF_LED3_DRIVE_CTL: drv_index = 2;
            default:            drv_index = -1;
        endcase
    endfunction

    // Converts a microsecond count to reference clock cycles. The result is
    // cut to the target field at each call site; the field widths are chosen
    // so that the largest count of each field still fits.
    function automatic int us_to_cycles(input int us);
        return us * CYC_PER_STEP;
    endfunction

    // One-hot emitter select; pulse-connect lights no emitter at all.
    function automatic logic [2:0] emitter_onehot(input ldc_pick_t p);
        case (p)
            PICK_DRV_ONE:   emitter_onehot = 3'h1;
            PICK_DRV_TWO:   emitter_onehot = 3'h2;
            PICK_DRV_THREE: emitter_onehot = 3'h4;
            default:        emitter_onehot = 3'h0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Driver control and trim registers
    // ------------------------------------------------------------------
    // Reserved bits are not stored, so a write that breaks the fixed pattern
    // cannot disturb the drivers; it simply reads back corrected.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DRV_COUNT; i++) begin
                drv[i].edge_rate     <= RST_RATE;
                drv[i].coarse_level  <= RST_COARSE;
                drv[i].full_strength <= RST_SCALE;
                drv[i].trim          <= RST_TRIM;
            end
        end else if (reg_wr) begin
            for (int i = 0; i < DRV_COUNT; i++) begin
                if (drv_index(reg_addr) == i) begin
                    drv[i].edge_rate     <= reg_wdata[POS_RATE_HI:POS_RATE_LO];
                    drv[i].coarse_level  <= reg_wdata[POS_COARSE_HI:POS_COARSE_LO];
                    drv[i].full_strength <= reg_wdata[POS_SCALE];
                end
            end
            if (reg_addr == OFF_LED_FINE_TRIM) begin
                drv[0].trim <= reg_wdata[POS_TRIM1_HI:POS_TRIM1_LO];
                drv[1].trim <= reg_wdata[POS_TRIM2_HI:POS_TRIM2_LO];
                drv[2].trim <= reg_wdata[POS_TRIM3_HI:POS_TRIM3_LO];
            end
        end
    end

    // ------------------------------------------------------------------
    // Time Slot A registers
    // ------------------------------------------------------------------
    // Pulse length, pulse delay and driver pick.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            first_slot_pulse_len   <= RST_LEN;
            first_slot_pulse_delay <= RST_DELAY;
            first_slot_driver_pick <= ldc_pick_t'(RST_PICK);
        end else if (reg_wr) begin
            if (reg_addr == OFF_SLOT_A_PULSE) begin
                first_slot_pulse_len   <= reg_wdata[POS_LEN_HI:POS_LEN_LO];
                first_slot_pulse_delay <= reg_wdata[POS_DELAY_HI:POS_DELAY_LO];
            end
            if (reg_addr == OFF_SLOT_A_DRIVER_SEL) begin
                first_slot_driver_pick <= ldc_pick_t'(reg_wdata[POS_PICK_HI:POS_PICK_LO]);
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Unmapped offsets read as zero.
    // A read and a write in one cycle return the old word, since the read
    // image is captured from the stored fields before the write lands.
    always_comb begin
        next_rdata = '0;
        case (reg_addr)
            OFF_LED1_DRIVE_CTL: next_rdata = drv_word(drv[0]);
            OFF_LED2_DRIVE_CTL: next_rdata = drv_word(drv[1]);
            OFF_LED3_DRIVE_CTL: next_rdata = drv_word(drv[2]);
            OFF_LED_FINE_TRIM: begin
                next_rdata[POS_TRIM3_HI:POS_TRIM3_LO] = drv[2].trim;
                next_rdata[POS_TRIM2_HI:POS_TRIM2_LO] = drv[1].trim;
                next_rdata[POS_TRIM1_HI:POS_TRIM1_LO] = drv[0].trim;
            end
            OFF_SLOT_A_PULSE: begin
                next_rdata[POS_LEN_HI:POS_LEN_LO]     = first_slot_pulse_len;
                next_rdata[POS_DELAY_HI:POS_DELAY_LO] = first_slot_pulse_delay;
            end
            OFF_SLOT_A_DRIVER_SEL: next_rdata[POS_PICK_HI:POS_PICK_LO] = first_slot_driver_pick;
            default: next_rdata = '0;
        endcase
    end

    // Read data is registered and marked valid for one cycle.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs toward drive and timing logic
    // ------------------------------------------------------------------
    // Settings are re-registered so every output comes from a flip-flop.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DRV_COUNT; i++) begin
                drv_cfg[i] <= '{RST_RATE, RST_COARSE, RST_SCALE, RST_TRIM};
            end
        end else begin
            for (int i = 0; i < DRV_COUNT; i++) begin
                drv_cfg[i] <= drv[i];
            end
        end
    end

    // Slot A shape, with microsecond fields also given as clock-cycle counts.
    // The cycle counts spare the sequencer a multiplier of its own.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            first_slot <= '0;
        end else begin
            first_slot.pulse_len       <= first_slot_pulse_len;
            first_slot.pulse_delay     <= first_slot_pulse_delay;
            first_slot.pulse_len_cyc   <= 11'(us_to_cycles(int'(first_slot_pulse_len)));
            first_slot.pulse_delay_cyc <= 14'(us_to_cycles(int'(first_slot_pulse_delay)));
            first_slot.emitter_sel     <= emitter_onehot(first_slot_driver_pick);
            first_slot.pulse_connect <= (first_slot_driver_pick == PICK_PULSE_CONNECT);
        end
    end

    // ------------------------------------------------------------------
    // Peak target per driver
    // ------------------------------------------------------------------
    // One multiplier chain per driver. The product is registered inside each
    // instance, so the targets lag the register contents by one cycle, the
    // same as the settings outputs; consumers may pair them freely.
    for (genvar g = 0; g < DRV_COUNT; g++) begin : g_target
        ldc_peak_target u_target (
            .ref_clk     (ref_clk),
            .rst         (rst),
            .cfg         (drv[g]),
            .peak_target (drv_peak_target[g])
        );
    end

endmodule

//--- inc/ldc_pkg.sv
// Package of constants and types for the LED drive configuration register bank.
package ldc_pkg;

    // ------------------------------------------------------------------
    // Register port and clock
    // ------------------------------------------------------------------
    localparam int ADDR_W        = 8;
    localparam int DATA_W        = 16;
    localparam int CLK_FREQ_MHZ  = 50;
    localparam int STEP_US       = 1;
    localparam int CYC_PER_STEP  = STEP_US * CLK_FREQ_MHZ;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_SLOT_A_DRIVER_SEL = 8'h14;
    localparam logic [7:0] OFF_LED3_DRIVE_CTL    = 8'h22;
    localparam logic [7:0] OFF_LED1_DRIVE_CTL    = 8'h23;
    localparam logic [7:0] OFF_LED2_DRIVE_CTL    = 8'h24;
    localparam logic [7:0] OFF_LED_FINE_TRIM     = 8'h25;
    localparam logic [7:0] OFF_SLOT_A_PULSE      = 8'h30;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int POS_RATE_LO   = 4;
    localparam int POS_RATE_HI   = 6;
    localparam int POS_COARSE_LO = 0;
    localparam int POS_COARSE_HI = 3;
    localparam int POS_RSVD_ONE  = 12;
    localparam int POS_SCALE     = 13;
    localparam int POS_TRIM3_LO  = 11;
    localparam int POS_TRIM3_HI  = 15;
    localparam int POS_TRIM2_LO  = 6;
    localparam int POS_TRIM2_HI  = 10;
    localparam int POS_TRIM1_LO  = 0;
    localparam int POS_TRIM1_HI  = 4;
    localparam int POS_LEN_LO    = 8;
    localparam int POS_LEN_HI    = 12;
    localparam int POS_DELAY_LO  = 0;
    localparam int POS_DELAY_HI  = 7;
    localparam int POS_PICK_LO   = 0;
    localparam int POS_PICK_HI   = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] RST_RATE   = 3'h0;
    localparam logic [3:0] RST_COARSE = 4'h0;
    localparam logic       RST_SCALE  = 1'h1;
    localparam logic       RSVD_ONE   = 1'h1;
    localparam logic [4:0] RST_TRIM   = 5'hC;
    localparam logic [4:0] RST_LEN    = 5'h3;
    localparam logic [7:0] RST_DELAY  = 8'h20;
    localparam logic [1:0] RST_PICK   = 2'h1;

    // ------------------------------------------------------------------
    // Peak current terms in fixed point: coarse in 0.1 mA, fine in 0.001,
    // scale in 0.1; the product is in units of 0.00001 mA.
    // ------------------------------------------------------------------
    localparam int COARSE_BASE = 503;
    localparam int COARSE_STEP = 198;
    localparam int FINE_BASE   = 740;
    localparam int FINE_STEP   = 22;
    localparam int SCALE_BASE  = 1;
    localparam int SCALE_STEP  = 9;
    localparam int TARGET_W    = 26;
    localparam int DRV_COUNT   = 3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PICK_PULSE_CONNECT = 2'h0,
        PICK_DRV_ONE       = 2'h1,
        PICK_DRV_TWO       = 2'h2,
        PICK_DRV_THREE     = 2'h3
    } ldc_pick_t;

    typedef struct packed {
        logic [2:0] edge_rate;
        logic [3:0] coarse_level;
        logic       full_strength;
        logic [4:0] trim;
    } ldc_drv_cfg_t;

    typedef struct packed {
        logic [4:0]  pulse_len;
        logic [7:0]  pulse_delay;
        logic [10:0] pulse_len_cyc;
        logic [13:0] pulse_delay_cyc;
        logic [2:0]  emitter_sel;
        logic        pulse_connect;
    } ldc_slot_t;

endpackage

//--- hdl/ldc_peak_target.sv
// Peak target current computation for one LED driver.
`timescale 1ns/100ps

module ldc_peak_target
    import ldc_pkg::*;
(
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst,
    // Driver settings in, target current out in units of 0.00001 mA
    input  wire ldc_drv_cfg_t        cfg,
    output      logic [TARGET_W-1:0] peak_target
);

    logic [11:0] coarse_term;
    logic [10:0] fine_term;
    logic [3:0]  scale_term;

    // The three factors, each scaled to an integer so no divider is needed.
    assign coarse_term = 12'(COARSE_BASE + COARSE_STEP * int'(cfg.coarse_level));
    assign fine_term   = 11'(FINE_BASE + FINE_STEP * int'(cfg.trim));
    assign scale_term  = 4'(SCALE_BASE + SCALE_STEP * int'(cfg.full_strength));

    // Registered product; one cycle of latency behind a settings change.
    // Each term is widened first, so the product is never cut at the width of one term.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            peak_target <= '0;
        end else begin
            peak_target <= TARGET_W'(coarse_term) * TARGET_W'(fine_term) * TARGET_W'(scale_term);
        end
    end

endmodule

//--- tb/ldc_regs_monitor.sv
// Port checker for the LED drive configuration register bank.
`timescale 1ns/100ps

module ldc_regs_monitor
    import ldc_pkg::*;
(
    // Clock and reset
    input wire logic                ref_clk,
    input wire logic                rst,
    // Register port
    input wire logic [ADDR_W-1:0]   reg_addr,
    input wire logic                reg_wr,
    input wire logic [DATA_W-1:0]   reg_wdata,
    input wire logic                reg_rd,
    input wire logic [DATA_W-1:0]   reg_rdata,
    input wire logic                reg_rvalid,
    // Settings seen by the drive and timing logic
    input wire ldc_drv_cfg_t        drv_cfg [DRV_COUNT],
    input wire logic [TARGET_W-1:0] drv_peak_target [DRV_COUNT],
    input wire ldc_slot_t           first_slot
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Write strobes per offset; a write is judged alone so a second one cannot mask a stale field.
    wire logic w14 = reg_wr && reg_addr == OFF_SLOT_A_DRIVER_SEL;
    wire logic w22 = reg_wr && reg_addr == OFF_LED3_DRIVE_CTL;
    wire logic w23 = reg_wr && reg_addr == OFF_LED1_DRIVE_CTL;
    wire logic w24 = reg_wr && reg_addr == OFF_LED2_DRIVE_CTL;
    wire logic w25 = reg_wr && reg_addr == OFF_LED_FINE_TRIM;
    wire logic w30 = reg_wr && reg_addr == OFF_SLOT_A_PULSE;

    property p_rate;
        w24 ##1 !w24 |=> drv_cfg[1].edge_rate == 3'($past(reg_wdata, 2) >> 4);
    endproperty
    a_rate: assert property (p_rate) else $error("edge rate not taken from write");
    property p_coarse;
        w23 ##1 !w23 |=> drv_cfg[0].coarse_level == 4'($past(reg_wdata, 2));
    endproperty
    a_coarse: assert property (p_coarse) else $error("coarse level not taken from write");
    property p_scale;
        w22 ##1 !w22 |=> drv_cfg[2].full_strength == 1'($past(reg_wdata, 2) >> 13);
    endproperty
    a_scale: assert property (p_scale) else $error("scale bit not taken from write");
    property p_trim;
        w25 ##1 !w25 |=> drv_cfg[2].trim == 5'($past(reg_wdata, 2) >> 11) && drv_cfg[1].trim == 5'($past(reg_wdata, 2) >> 6) && drv_cfg[0].trim == 5'($past(reg_wdata, 2));
    endproperty
    a_trim: assert property (p_trim) else $error("trim fields misplaced");
    // The product is checked outright, so a wrong term or a stale operand both show.
    property p_peak;
        !$past(rst) |-> drv_peak_target[1] == 26'((32'h1F7 + 32'hC6 * drv_cfg[1].coarse_level) * (32'h2E4 + 32'h16 * drv_cfg[1].trim) * (drv_cfg[1].full_strength ? 32'hA : 32'h1));
    endproperty
    a_peak: assert property (p_peak) else $error("peak target wrong");
    property p_len;
        w30 ##1 !w30 |=> first_slot.pulse_len == 5'($past(reg_wdata, 2) >> 8) && first_slot.pulse_delay == 8'($past(reg_wdata, 2));
    endproperty
    a_len: assert property (p_len) else $error("slot pulse fields wrong");
    property p_cyc;
        !$past(rst) |-> first_slot.pulse_delay_cyc == first_slot.pulse_delay * 14'h32 && first_slot.pulse_len_cyc == first_slot.pulse_len * 11'h32;
    endproperty
    a_cyc: assert property (p_cyc) else $error("microsecond scaling wrong");
    property p_pick;
        w14 ##1 !w14 |=> first_slot.emitter_sel == 3'((4'h1 << 2'($past(reg_wdata, 2))) >> 1) && first_slot.pulse_connect == (2'($past(reg_wdata, 2)) == 2'h0);
    endproperty
    a_pick: assert property (p_pick) else $error("driver pick decode wrong");
endmodule

bind ldc_regs ldc_regs_monitor u_mon (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .drv_cfg(drv_cfg),
    .drv_peak_target(drv_peak_target), .first_slot(first_slot));

//--- tb/tb_ldc_regs.sv
// Self-checking testbench for the LED drive configuration register bank.
`timescale 1ns/100ps

module tb_ldc_regs
    import ldc_pkg::*;
;
    logic                ref_clk = 1'b0;
    logic                rst = 1'b1;
    logic [ADDR_W-1:0]   reg_addr = 8'h00;
    logic                reg_wr = 1'b0;
    logic [DATA_W-1:0]   reg_wdata = 16'h0000;
    logic                reg_rd = 1'b0;
    logic [DATA_W-1:0]   reg_rdata;
    logic                reg_rvalid;
    ldc_drv_cfg_t        drv_cfg [DRV_COUNT];
    logic [TARGET_W-1:0] drv_peak_target [DRV_COUNT];
    ldc_slot_t           first_slot;
    int                  mismatches = 0;
    int                  cmp_count = 0;

    ldc_regs DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .drv_cfg(drv_cfg),
        .drv_peak_target(drv_peak_target), .first_slot(first_slot));

    // Free-running 50 MHz clock.
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // Compares with case equality so an unknown never counts as a match.
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One-cycle write strobe, then two edges so every derived output has settled.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    // One-cycle read strobe; the answer is awaited under a bound and compared.
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        int n = 0;
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n == 4) begin
            mismatches++;
            $display("BAD t=%0t read answer never came", $time);
            stop_test();
        end
        chk(reg_rdata, e);
    endtask

    // Main sequence; an unmapped write comes first so the reset table also proves it was ignored.
    initial begin
        int i;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        wr(8'h40, 16'hFFFF);
        chk(drv_peak_target[0], 48'h4D0F08);
        chk(first_slot, {5'h03, 8'h20, 11'h096, 14'h0640, 3'h1, 1'b0});
        rd(8'h14, 16'h0001);
        rd(8'h22, 16'h3000);
        rd(8'h25, 16'h630C);
        rd(8'h30, 16'h0320);
        rd(8'h40, 16'h0000);
        $display("reset test done");
        for (i = 0; i < 3; i++) begin
            wr(8'h22 + 8'((i + 1) % 3), 16'h107F);
            rd(8'h22 + 8'((i + 1) % 3), 16'h107F);
            chk(drv_cfg[i], {3'h7, 4'hF, 1'b0, 5'hC});
            chk(drv_peak_target[i], 48'h3534AC);
        end
        wr(8'h24, 16'h3052);
        chk(drv_cfg[1], {3'h5, 4'h2, 1'b1, 5'hC});
        chk(drv_peak_target[1], 48'h89B9A8);
        $display("driver test done");
        wr(8'h25, 16'h8C03);
        rd(8'h25, 16'h8C03);
        chk({drv_cfg[2].trim, drv_cfg[1].trim, drv_cfg[0].trim}, {5'h11, 5'h10, 5'h03});
        chk(drv_peak_target[2], 48'h3B08FA);
        wr(8'h25, 16'hFFDF);
        chk(drv_peak_target[0], 48'h4B5B6E);
        $display("trim test done");
        wr(8'h30, 16'h1FFF);
        chk(first_slot, {5'h1F, 8'hFF, 11'h60E, 14'h31CE, 3'h1, 1'b0});
        // Read and write in one cycle: the read must still see the old word.
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_rd <= 1'b1;
        reg_wdata <= 16'h0A05;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        chk({reg_rvalid, reg_rdata}, {1'b1, 16'h1FFF});
        rd(8'h30, 16'h0A05);
        chk(first_slot, {5'h0A, 8'h05, 11'h1F4, 14'h00FA, 3'h1, 1'b0});
        $display("slot test done");
        for (i = 0; i < 4; i++) begin
            wr(8'h14, 16'(i));
            rd(8'h14, 16'(i));
            chk({first_slot.emitter_sel, first_slot.pulse_connect}, i == 0 ? 4'h1 : {3'(1 << (i - 1)), 1'b0});
        end
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(drv_cfg[2], {3'h0, 4'h0, 1'b1, 5'hC});
        chk(first_slot, {5'h03, 8'h20, 11'h096, 14'h0640, 3'h1, 1'b0});
        rd(8'h14, 16'h0001);
        $display("pick and reset test done");
        stop_test();
    end
endmodule
